// [src/wdt_top.sv]
// Purpose: Eight-bit watchdog counter with chip reset on overflow, APB slave
// Assumes: Oscillator clock equals core_clk_in; APB data 32 bits
// Notes: Read data is captured in the setup cycle, one wait-free access
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps

// Overview of operation
// R01: Eight-bit counter steps by one on each selected input clock tick.
// R02: Tick source is system clock over 8192 or watch clock over 32.
// R03: Overflow without rewrite drives an internal reset of the whole chip.
// R04: Loaded counter value sets overflow time from 1 to 256 ticks.
// R05: Watchdog can be put alone into module standby while unused.
// R06: Reset loads control 0xaa, counter 0x00, clock stop 0xff, port 0x00.
// R07: Write-inhibit bits always read one and store nothing.
// R08: Counter write enable changes only when bit 7 is written zero.
// R09: Counter writes ignored unless counter write enable is one.
// R10: Register write enable changes only when bit 5 is written zero.
// R11: Register write enable gates writes to run bit and reset flag.
// R12: Run bit starts and stops counting; needs enable and inhibit zero.
// R13: Wrap from 0xff to 0x00 raises chip reset and sets reset flag.
// R14: Chip reset pulse lasts 512 oscillator cycles.
// R15: Clock select zero picks system divide, one picks watch divide.
// R16: Inhibited bits keep old values; enabled bits in same write update.
// R17: Software reloads the counter before overflow in normal operation.
module wdt_top
  import wdt_pkg::*;
#(
  parameter int unsigned SYS_DIV = SYS_DIV_DEF,
  parameter int unsigned WCLK_DIV = WCLK_DIV_DEF
) (
  // Clock, reset, enable
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [APB_AW-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Watch clock pin
  input wire logic wclk_in,
  // System outputs
  output logic chip_reset_out,
  output logic irq_out,
  output logic standby_out
);

  wdt_tick_if tif ();

  logic pready_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  logic cwe_reg;
  logic sre_reg;
  logic run_reg;
  logic flag_reg;
  logic [7:0] cnt_reg;
  logic [7:0] pfs3_reg;
  logic [7:0] module_clock_stop_two_reg;
  logic [7:0] irq_stat_reg;
  logic [7:0] irq_stat_next;
  logic [7:0] irq_mask_reg;
  logic irq_reg;
  logic standby_reg;
  logic chip_reset_reg;
  logic [8:0] rst_cnt_reg;
  wdt_rst_state_e rst_state_reg;

  logic [7:0] wd;
  logic [7:0] csr_rd;
  logic [7:0] rd_mux;
  logic hit;
  logic acc;
  logic wr_stb;
  logic wr_csr;
  logic wr_cnt;
  logic cnt_load;
  logic cnt_rej;
  logic tick_run;
  logic ovf;

  function automatic logic is_reg(input logic [APB_AW-1:0] a, input logic [IDX_W-1:0] idx);
    return a == wdt_addr(idx);
  endfunction : is_reg

  assign wd = pwdata_in[7:0];
  assign acc = psel_in && penable_in && pready_reg && ce_in;
  assign wr_stb = acc && pwrite_in && pstrb_in[0];
  assign wr_csr = wr_stb && is_reg(paddr_in, IDX_CSR);
  assign wr_cnt = wr_stb && is_reg(paddr_in, IDX_CNT);
  assign cnt_load = wr_cnt && cwe_reg; // [R09]
  assign cnt_rej = wr_cnt && !cwe_reg;
  assign tick_run = tif.tick && run_reg; // [R12]
  assign ovf = tick_run && cnt_reg == CNT_MAX && !cnt_load; // [R13]

  // Inhibit positions always read as one [R07]
  assign csr_rd = CSR_INH_ONES | {1'b0, cwe_reg, 1'b0, sre_reg, 1'b0, run_reg, 1'b0, flag_reg};

  always_comb begin
    hit = 1'b1;
    rd_mux = 8'h00;
    if (is_reg(paddr_in, IDX_CSR)) begin
      rd_mux = csr_rd;
    end else if (is_reg(paddr_in, IDX_CNT)) begin
      rd_mux = cnt_reg;
    end else if (is_reg(paddr_in, IDX_PFS3)) begin
      rd_mux = pfs3_reg;
    end else if (is_reg(paddr_in, IDX_MODULE_CLOCK_STOP_TWO)) begin
      rd_mux = module_clock_stop_two_reg;
    end else if (is_reg(paddr_in, IDX_IRQ_STAT)) begin
      rd_mux = irq_stat_reg;
    end else if (is_reg(paddr_in, IDX_IRQ_MASK)) begin
      rd_mux = irq_mask_reg;
    end else begin
      hit = 1'b0;
    end
  end

  // Answer prepared in setup so every output leaves a flip-flop
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (ce_in) begin
      if (psel_in && !penable_in) begin
        pready_reg <= 1'b1;
        prdata_reg <= {24'h00_0000, rd_mux};
        pslverr_reg <= !hit;
      end else if (acc) begin
        pready_reg <= 1'b0;
        pslverr_reg <= 1'b0;
      end
    end
  end

  // Each bit judged against its own inhibit in the same write [R16]
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cwe_reg <= CSR_RST[CSR_CWE]; // [R06]
      sre_reg <= CSR_RST[CSR_SRE];
      run_reg <= CSR_RST[CSR_RUN];
    end else if (ce_in && wr_csr) begin
      if (!wd[CSR_CWE_INH]) begin
        cwe_reg <= wd[CSR_CWE]; // [R08]
      end
      if (!wd[CSR_SRE_INH]) begin
        sre_reg <= wd[CSR_SRE]; // [R10]
      end
      if (sre_reg && !wd[CSR_RUN_INH]) begin
        run_reg <= wd[CSR_RUN]; // [R11] [R12]
      end
    end
  end

  // Flag only cleared by writing zero; an overflow in that cycle wins
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      flag_reg <= CSR_RST[CSR_FLAG];
    end else if (ce_in) begin
      if (ovf) begin
        flag_reg <= 1'b1; // [R13]
      end else if (wr_csr && sre_reg && !wd[CSR_FLAG_INH] && !wd[CSR_FLAG]) begin
        flag_reg <= 1'b0; // [R11]
      end
    end
  end

  // Software load takes priority over a tick in the same cycle [R04]
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_reg <= CNT_RST; // [R06]
    end else if (ce_in) begin
      if (cnt_load) begin
        cnt_reg <= wd; // [R09]
      end else if (tick_run) begin
        cnt_reg <= cnt_reg + 8'h01; // [R01]
      end
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pfs3_reg <= PFS3_RST; // [R06]
      module_clock_stop_two_reg <= MODULE_CLOCK_STOP_TWO_RST;
      irq_mask_reg <= IRQ_RST;
    end else if (ce_in && wr_stb) begin
      if (is_reg(paddr_in, IDX_PFS3)) begin
        pfs3_reg <= wd;
      end
      if (is_reg(paddr_in, IDX_MODULE_CLOCK_STOP_TWO)) begin
        module_clock_stop_two_reg <= wd;
      end
      if (is_reg(paddr_in, IDX_IRQ_MASK)) begin
        irq_mask_reg <= wd;
      end
    end
  end

  // Standby request waits until the run bit is cleared [R05]
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      standby_reg <= 1'b0;
    end else if (ce_in) begin
      standby_reg <= !module_clock_stop_two_reg[MODULE_CLOCK_STOP_TWO_WD_BIT] && !run_reg;
    end
  end

  // Prescaler runs only while counting and not in standby
  assign tif.cen = ce_in;
  assign tif.count_en = run_reg && !standby_reg; // [R05] [R12]
  assign tif.sel = pfs3_reg[PFS3_CKS_BIT]; // [R15]
  assign tif.wclk_pin = wclk_in;

  wdt_tick #(
    .SYS_DIV(SYS_DIV),
    .WCLK_DIV(WCLK_DIV)
  ) u_tick (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .tif(tif)
  );

  // Reset pulse starts one cycle after the overflow; repeats are ignored
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rst_state_reg <= WDT_ST_IDLE;
      rst_cnt_reg <= 9'h000;
      chip_reset_reg <= 1'b0;
    end else if (ce_in) begin
      case (rst_state_reg)
        WDT_ST_IDLE: begin
          if (ovf) begin
            rst_state_reg <= WDT_ST_RST;
            rst_cnt_reg <= 9'h000;
            chip_reset_reg <= 1'b1; // [R03]
          end
        end
        WDT_ST_RST: begin
          if (rst_cnt_reg == RST_CNT_LAST) begin
            rst_state_reg <= WDT_ST_IDLE;
            chip_reset_reg <= 1'b0; // [R14]
          end else begin
            rst_cnt_reg <= rst_cnt_reg + 9'h001;
          end
        end
        default: begin
          rst_state_reg <= WDT_ST_IDLE;
          chip_reset_reg <= 1'b0;
        end
      endcase
    end
  end

  // Pulse length as seen on the pin, kept apart from the sequencer's own count
  logic [9:0] pulse_len_reg;
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pulse_len_reg <= 10'h000;
    end else if (ce_in) begin
      pulse_len_reg <= chip_reset_reg ? pulse_len_reg + 10'h001 : 10'h000;
    end
  end

  // Sticky events: set beats a write-one clear in the same cycle
  always_comb begin
    irq_stat_next = irq_stat_reg;
    if (wr_stb && is_reg(paddr_in, IDX_IRQ_STAT)) begin
      irq_stat_next = irq_stat_reg & ~wd;
    end
    irq_stat_next[IRQ_OVF] = irq_stat_next[IRQ_OVF] | ovf;
    irq_stat_next[IRQ_WREJ] = irq_stat_next[IRQ_WREJ] | cnt_rej;
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_stat_reg <= IRQ_RST;
      irq_reg <= 1'b0;
    end else if (ce_in) begin
      irq_stat_reg <= irq_stat_next;
      irq_reg <= |(irq_stat_next & irq_mask_reg);
    end
  end

  assign prdata_out = prdata_reg;
  assign pready_out = pready_reg;
  assign pslverr_out = pslverr_reg;
  assign chip_reset_out = chip_reset_reg;
  assign irq_out = irq_reg;
  assign standby_out = standby_reg;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  AST_RESET_VALUES: assert property (disable iff (1'b0) rst_in |-> // [R06]
    (csr_rd == CSR_RST && cnt_reg == CNT_RST && module_clock_stop_two_reg == MODULE_CLOCK_STOP_TWO_RST && pfs3_reg == PFS3_RST))
    else $error("reset values wrong");
  AST_INHIBIT_ONES: assert property ((acc && !pwrite_in && is_reg(paddr_in, IDX_CSR)) |-> // [R07]
    (prdata_out[7:0] & CSR_INH_ONES) == CSR_INH_ONES)
    else $error("inhibit bit not read as one");
  AST_COUNT_STEP: assert property ((ce_in && tick_run && !cnt_load) |=> // [R01]
    cnt_reg == $past(cnt_reg) + 8'h01)
    else $error("counter did not step");
  AST_WRAP: assert property (ovf |=> (cnt_reg == 8'h00 && flag_reg && chip_reset_out)) // [R13]
    else $error("wrap did not flag and reset");
  AST_PULSE_MAX: assert property (chip_reset_out |-> pulse_len_reg < RST_PULSE_CYC) // [R14]
    else $error("reset pulse too long");
  AST_PULSE_END: assert property ($fell(chip_reset_out) |-> // [R14]
    $past(rst_cnt_reg) == RST_CNT_LAST)
    else $error("reset pulse ended early");
  AST_RST_DELAY: assert property ((ce_in && ovf && !chip_reset_out) |=> chip_reset_out) // [R03]
    else $error("chip reset not one cycle after overflow");
  AST_CWE_HOLD: assert property ((wr_csr && wd[CSR_CWE_INH]) |=> $stable(cwe_reg)) // [R08]
    else $error("counter write enable changed while inhibited");
  AST_SRE_HOLD: assert property ((wr_csr && wd[CSR_SRE_INH]) |=> $stable(sre_reg)) // [R10]
    else $error("register write enable changed while inhibited");
  AST_RUN_GATE: assert property ((wr_csr && !sre_reg) |=> $stable(run_reg)) // [R11]
    else $error("run bit changed without register write enable");
  AST_CNT_IGNORE: assert property ((wr_cnt && !cwe_reg && !tick_run) |=> // [R09]
    $stable(cnt_reg))
    else $error("counter write not ignored");
  AST_STOPPED: assert property ((!run_reg && !cnt_load) |=> $stable(cnt_reg)) // [R12]
    else $error("counter moved while stopped");
  AST_STANDBY_FREEZE: assert property (standby_reg |-> !tif.count_en) // [R05]
    else $error("prescaler running in standby");
  AST_STANDBY_RUN: assert property ((ce_in && run_reg) |=> !standby_reg) // [R05]
    else $error("standby entered while running");
  AST_LOAD: assert property (cnt_load |=> cnt_reg == $past(wd)) // [R09]
    else $error("counter write not loaded");
  AST_FLAG_GATE: assert property ((wr_csr && !sre_reg && !ovf) |=> // [R11]
    $stable(flag_reg))
    else $error("reset flag changed without register write enable");

  COV_OVERFLOW: cover property (ovf);
  COV_RELOAD: cover property (cnt_load && run_reg);
  COV_STANDBY: cover property ($rose(standby_reg));
  COV_PULSE_DONE: cover property ($fell(chip_reset_out));

endmodule : wdt_top

// [src/wdt_pkg.sv]
// Purpose: Constants shared by the watchdog timer design files
// Assumes: APB byte address is four times the register index
// Notes: Register indices double as word indices on the bus
package wdt_pkg;

  localparam int unsigned APB_AW = 18;
  localparam int unsigned IDX_W = 16;

  // Register indices
  localparam logic [IDX_W-1:0] IDX_CSR = 16'hffb2;
  localparam logic [IDX_W-1:0] IDX_CNT = 16'hffb3;
  localparam logic [IDX_W-1:0] IDX_PFS3 = 16'hffca;
  localparam logic [IDX_W-1:0] IDX_MODULE_CLOCK_STOP_TWO = 16'hfffb;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 16'hffd0;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 16'hffd1;

  // Reset values
  localparam logic [7:0] CSR_RST = 8'haa;
  localparam logic [7:0] CNT_RST = 8'h00;
  localparam logic [7:0] PFS3_RST = 8'h00;
  localparam logic [7:0] MODULE_CLOCK_STOP_TWO_RST = 8'hff;
  localparam logic [7:0] IRQ_RST = 8'h00;

  // Control/status field positions; inhibit bits are the odd ones
  localparam int unsigned CSR_CWE_INH = 7;
  localparam int unsigned CSR_CWE = 6;
  localparam int unsigned CSR_SRE_INH = 5;
  localparam int unsigned CSR_SRE = 4;
  localparam int unsigned CSR_RUN_INH = 3;
  localparam int unsigned CSR_RUN = 2;
  localparam int unsigned CSR_FLAG_INH = 1;
  localparam int unsigned CSR_FLAG = 0;
  localparam logic [7:0] CSR_INH_ONES = 8'haa;
  localparam int unsigned PFS3_CKS_BIT = 5;
  localparam int unsigned MODULE_CLOCK_STOP_TWO_WD_BIT = 2;

  // Interrupt status bits
  localparam int unsigned IRQ_OVF = 0;
  localparam int unsigned IRQ_WREJ = 1;

  // Timing counts
  localparam int unsigned SYS_DIV_DEF = 8192;
  localparam int unsigned WCLK_DIV_DEF = 32;
  localparam int unsigned RST_PULSE_CYC = 512;
  localparam logic [8:0] RST_CNT_LAST = 9'h1ff;
  localparam logic [7:0] CNT_MAX = 8'hff;

  typedef enum logic [1:0] {
    WDT_ST_IDLE = 2'b01,
    WDT_ST_RST = 2'b10
  } wdt_rst_state_e;

  function automatic logic [APB_AW-1:0] wdt_addr(input logic [IDX_W-1:0] idx);
    return {idx, 2'b00};
  endfunction : wdt_addr

endpackage : wdt_pkg

// [src/wdt_tick_if.sv]
// Purpose: Carries prescaler control and count tick between watchdog modules
// Assumes: Single clock domain
// Notes: wclk_pin is raw and is synchronised in the prescaler
`timescale 1ns/1ps
interface wdt_tick_if;
  logic cen;
  logic count_en;
  logic sel;
  logic wclk_pin;
  logic tick;
  modport ctl (output cen, output count_en, output sel, output wclk_pin, input tick);
  modport gen (input cen, input count_en, input sel, input wclk_pin, output tick);
endinterface : wdt_tick_if

// [src/wdt_tick.sv]
// Purpose: Watchdog input clock prescaler, system or watch clock source
// Assumes: Watch clock pin is asynchronous and much slower than core_clk_in
// Notes: Prescalers restart from zero each time counting is enabled
`timescale 1ns/1ps
module wdt_tick
  import wdt_pkg::*;
#(
  parameter int unsigned SYS_DIV = SYS_DIV_DEF,
  parameter int unsigned WCLK_DIV = WCLK_DIV_DEF
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // Control and tick
  wdt_tick_if.gen tif
);

  localparam int unsigned SW = $clog2(SYS_DIV);
  localparam int unsigned WW = $clog2(WCLK_DIV);
  localparam logic [SW-1:0] SYS_LAST = SW'(SYS_DIV - 1);
  localparam logic [WW-1:0] WCLK_LAST = WW'(WCLK_DIV - 1);

  logic [2:0] wsync_reg;
  logic wlvl_reg;
  logic [SW-1:0] sys_cnt_reg;
  logic [WW-1:0] wcnt_reg;
  logic tick_reg;
  logic wrise;

  // Watch level changes only once the two later stages agree
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wsync_reg <= 3'h0;
      wlvl_reg <= 1'b0;
    end else if (tif.cen) begin
      wsync_reg <= {wsync_reg[1:0], tif.wclk_pin};
      if (wsync_reg[1] == wsync_reg[2]) begin
        wlvl_reg <= wsync_reg[2];
      end
    end
  end

  assign wrise = (wsync_reg[1] == wsync_reg[2]) && wsync_reg[2] && !wlvl_reg;

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sys_cnt_reg <= '0;
      wcnt_reg <= '0;
      tick_reg <= 1'b0;
    end else if (tif.cen) begin
      if (!tif.count_en) begin
        sys_cnt_reg <= '0;
        wcnt_reg <= '0;
        tick_reg <= 1'b0;
      end else begin
        sys_cnt_reg <= (sys_cnt_reg == SYS_LAST) ? '0 : sys_cnt_reg + 1'b1;
        if (wrise) begin
          wcnt_reg <= (wcnt_reg == WCLK_LAST) ? '0 : wcnt_reg + 1'b1;
        end
        // Source select: 0 system divide, 1 watch divide [R02] [R15]
        tick_reg <= tif.sel ? (wrise && wcnt_reg == WCLK_LAST) : (sys_cnt_reg == SYS_LAST);
      end
    end
  end

  assign tif.tick = tick_reg;

  AST_SYS_PERIOD: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R02]
    (tif.cen && tif.count_en && !tif.sel && sys_cnt_reg == SYS_LAST) |=> tick_reg)
    else $error("system divide tick missing");

endmodule : wdt_tick

// [verification/wdt_top_tb_top.sv]
// Purpose: Self-checking bench for the watchdog timer block
// Assumes: Prescale divides shortened to 8 and 2 to keep the run short
// Notes: APB results flow through an expectation queue to a monitor process
`timescale 1ns/1ps
module wdt_top_tb_top
  import wdt_pkg::*;
;
  localparam int unsigned SYS_D = 8;
  localparam int unsigned WC_D = 2;

  typedef struct packed {
    logic wr;
    logic [31:0] d;
    logic e;
  } wdt_exp_s;

  logic core_clk_in;
  logic rst_in;
  logic ce_in;
  logic psel_in;
  logic penable_in;
  logic pwrite_in;
  logic [APB_AW-1:0] paddr_in;
  logic [31:0] pwdata_in;
  logic [3:0] pstrb_in;
  logic [31:0] prdata_out;
  logic pready_out;
  logic pslverr_out;
  logic wclk_in;
  logic chip_reset_out;
  logic irq_out;
  logic standby_out;
  wdt_exp_s exp_q[$];
  wdt_exp_s cur;
  int err_total;
  int n_tests;
  int cyc;
  logic [7:0] v;

  wdt_top #(.SYS_DIV(SYS_D), .WCLK_DIV(WC_D)) DUT (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .psel_in(psel_in),
    .penable_in(penable_in),
    .pwrite_in(pwrite_in),
    .paddr_in(paddr_in),
    .pwdata_in(pwdata_in),
    .pstrb_in(pstrb_in),
    .prdata_out(prdata_out),
    .pready_out(pready_out),
    .pslverr_out(pslverr_out),
    .wclk_in(wclk_in),
    .chip_reset_out(chip_reset_out),
    .irq_out(irq_out),
    .standby_out(standby_out)
  );

  task end_sim;
    if (err_total == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // Holds the request until pready is seen, released only after the completion edge
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] d,
                     input logic e);
    wdt_exp_s x;
    int n;
    x.wr = wr;
    x.d = d;
    x.e = e;
    exp_q.push_back(x);
    @(posedge core_clk_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= wr;
    paddr_in <= {idx, 2'b00};
    pwdata_in <= wr ? d : 32'h0;
    @(posedge core_clk_in);
    penable_in <= 1'b1;
    n = 0;
    // Ready is judged only on the rising edge that completes the access
    do begin
      @(posedge core_clk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 50);
    if (pready_out !== 1'b1) begin
      err_total++;
      $display("MISMATCH %0t no pready", $time);
    end
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    apb(1'b1, idx, {24'h0, d}, 1'b0);
  endtask : wr

  task automatic rd(input logic [15:0] idx, input logic [7:0] d);
    apb(1'b0, idx, {24'h0, d}, 1'b0);
  endtask : rd

  // Time from the run write to the reset rise, then the pulse width
  task automatic ovf_check(input int lo, input int hi);
    int n;
    n = 0;
    while (chip_reset_out !== 1'b1 && n <= hi) begin
      @(negedge core_clk_in);
      n++;
    end
    chk({31'h0, (n >= lo && n <= hi)}, 32'h1, "overflow time");
    n = 0;
    while (chip_reset_out === 1'b1 && n < 600) begin
      n++;
      @(negedge core_clk_in);
    end
    chk(32'(n), 32'(RST_PULSE_CYC), "reset pulse width");
  endtask : ovf_check

  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end

  // Watch clock pin, slow and unrelated to the counter period
  initial begin
    wclk_in = 1'b0;
    forever begin
      repeat (20) @(posedge core_clk_in);
      wclk_in <= ~wclk_in;
    end
  end

  always @(posedge core_clk_in) begin
    if (psel_in && penable_in && pready_out === 1'b1) begin
      if (exp_q.size() == 0) begin
        err_total++;
        $display("MISMATCH %0t unexpected transfer", $time);
      end else begin
        cur = exp_q.pop_front();
        chk({31'h0, pslverr_out}, {31'h0, cur.e}, "error response");
        if (!cur.wr) begin
          chk(prdata_out, cur.d, "read data");
        end
      end
    end
  end

  always @(posedge core_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      end_sim();
    end
  end

  initial begin
    err_total = 0;
    n_tests = 0;
    cyc = 0;
    rst_in = 1'b0;
    ce_in = 1'b1;
    psel_in = 1'b0;
    penable_in = 1'b0;
    pwrite_in = 1'b0;
    paddr_in = '0;
    pwdata_in = 32'h0;
    pstrb_in = 4'hf;
    void'($urandom(65));
    // Raised on an edge so every flop sees a real reset edge
    @(posedge core_clk_in);
    rst_in <= 1'b1;
    repeat (12) @(posedge core_clk_in);
    rst_in <= 1'b0;
    rd(IDX_CSR, 8'haa);
    rd(IDX_CNT, 8'h00);
    rd(IDX_PFS3, 8'h00);
    rd(IDX_MODULE_CLOCK_STOP_TWO, 8'hff);
    wr(IDX_IRQ_MASK, 8'h01);
    wr(IDX_CSR, 8'hff);
    rd(IDX_CSR, 8'haa);
    // Register write enable is still zero, so run and flag must hold
    wr(IDX_CSR, 8'h05);
    rd(IDX_CSR, 8'haa);
    wr(IDX_CNT, 8'h5a);
    rd(IDX_CNT, 8'h00);
    rd(IDX_IRQ_STAT, 8'h02);
    chk({31'h0, irq_out}, 32'h0, "masked irq");
    wr(IDX_IRQ_STAT, 8'h02);
    rd(IDX_IRQ_STAT, 8'h00);
    wr(IDX_CSR, 8'h70);
    rd(IDX_CSR, 8'hea);
    repeat (4) begin
      v = 8'($urandom);
      wr(IDX_CNT, v);
      rd(IDX_CNT, v);
    end
    // Two ticks from 0xfe to wrap on the system clock divider
    wr(IDX_CNT, 8'hfe);
    // Run bit uses the write enable held before the write, so set it first
    wr(IDX_CSR, 8'hda);
    wr(IDX_CSR, 8'ha6);
    ovf_check(2 * SYS_D - 4, 2 * SYS_D + 8);
    chk({31'h0, irq_out}, 32'h1, "overflow irq");
    rd(IDX_CSR, 8'hff);
    wr(IDX_IRQ_STAT, 8'h01);
    rd(IDX_IRQ_STAT, 8'h00);
    chk({31'h0, irq_out}, 32'h0, "irq cleared");
    // Reloads closer than two ticks keep the running counter from wrapping
    repeat (8) begin
      wr(IDX_CNT, 8'hfe);
    end
    chk({31'h0, chip_reset_out}, 32'h0, "reset despite reloads");
    wr(IDX_CSR, 8'h10);
    rd(IDX_CSR, 8'hba);
    wr(IDX_PFS3, 8'h20);
    rd(IDX_PFS3, 8'h20);
    // Byte lane 0 off: the write is dropped without an error
    pstrb_in <= 4'he;
    wr(IDX_PFS3, 8'h00);
    pstrb_in <= 4'hf;
    rd(IDX_PFS3, 8'h20);
    wr(IDX_CSR, 8'h50);
    rd(IDX_CSR, 8'hfa);
    wr(IDX_CNT, 8'hfe);
    wr(IDX_CSR, 8'h14);
    // Watch source is far slower; a system-divided tick would wrap near 18
    ovf_check(100, 400);
    wr(IDX_CSR, 8'h10);
    rd(IDX_CSR, 8'hba);
    wr(IDX_MODULE_CLOCK_STOP_TWO, 8'hfb);
    rd(IDX_MODULE_CLOCK_STOP_TWO, 8'hfb);
    chk({31'h0, standby_out}, 32'h1, "standby on");
    wr(IDX_MODULE_CLOCK_STOP_TWO, 8'hff);
    rd(IDX_MODULE_CLOCK_STOP_TWO, 8'hff);
    chk({31'h0, standby_out}, 32'h0, "standby off");
    apb(1'b0, 16'h0000, 32'h0, 1'b1);
    repeat (3) @(posedge core_clk_in);
    chk(32'(exp_q.size()), 32'h0, "transfers outstanding");
    end_sim();
  end

endmodule : wdt_top_tb_top
